// ### sacs_pkg.sv
/*
 * constants, control carrier and state codes of the converter sequencer.
 * assumes one clock; all cycle figures are in periods of that clock.
 */
// Operation
// - start strobe with offset-null request high starts conversion without offset null
// - start with offset-null request low runs offset-null cycle before conversion
// - chip select and read low present latched result on result bus
// - self-trim request low resets device and starts full calibration
// - select and self-trim low, read high: test mode drives bits 2,3,5,6
// - select and convert strobe low reset logic and abort conversion
// - started calibration cannot be reset or aborted by any input
// - power-up runs a 1396-cycle calibration without host request
// - calibration stores offset and gain corrections, applied to every conversion
// - result is 13-bit two's complement, 4095 positive, 4096 negative codes
// - hold command comes 7 clock periods after convert strobe rises
// - conversion-active output low throughout conversion and calibration
// - result-ready low on latch, high on read, start or calibration
// - offset-null cycle adds 26 clock periods to conversion time
package sacs_pkg;
	localparam int RES_W = 13;
	localparam int CNT_W = 11;
	// figures in clock periods
	localparam int CAL_PERIODS = 1396;
	localparam int ACQ_PERIODS = 7;
	localparam int AZ_PERIODS = 26;
	// cycle counts derived from the periods at one count per clock
	localparam logic [CNT_W-1:0] CAL_CYC = CNT_W'(CAL_PERIODS);
	localparam logic [CNT_W-1:0] ACQ_CYC = CNT_W'(ACQ_PERIODS);
	localparam logic [CNT_W-1:0] AZ_CYC = CNT_W'(AZ_PERIODS);
	localparam logic [CNT_W-1:0] SAR_CYC = CNT_W'(RES_W);
	localparam logic [CNT_W-1:0] CNT_LAST = 11'h001;
	// calibration phase ends and offset-null reload point
	localparam logic [CNT_W-1:0] CAL_OFS_LAST = CNT_W'(CAL_PERIODS - RES_W + 1);
	localparam logic [CNT_W-1:0] CAL_GAIN_LAST = CNT_W'(CAL_PERIODS - 2 * RES_W + 1);
	localparam logic [CNT_W-1:0] AZ_LOAD = CNT_W'(RES_W + 1);
	// code values
	localparam logic [RES_W-1:0] SAR_INIT = 13'h1000;
	localparam logic [RES_W-1:0] SAR_ZERO = 13'h0000;
	localparam logic [RES_W-1:0] GAIN_REF = 13'h0fff;
	localparam logic [RES_W-1:0] POS_MAX = 13'h0fff;
	localparam logic [RES_W-1:0] NEG_MIN = 13'h1000;
	localparam logic [RES_W-1:0] TEST_MASK = 13'h006c;
	localparam logic [RES_W-1:0] OE_ALL = 13'h1fff;
	localparam int GAIN_SHIFT = 12;
	localparam int CTL_W = 5;
	localparam logic [CTL_W-1:0] CTL_IDLE = 5'h1f;

	typedef struct packed {
		logic cs_n;
		logic wr_n;
		logic rd_n;
		logic cal_n;
		logic offset_null_request_n;
	} sacs_ctl_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_AZ = 3'b001,
		ST_ACQ = 3'b010,
		ST_CONV = 3'b011,
		ST_CAL = 3'b100
	} sacs_state_t;
endpackage

// ### sacs_sync.sv
/*
 * two-flop synchroniser for the host control strobes.
 * assumes inputs idle high; first stage feeds only the second.
 */
`timescale 1ns/100ps
`default_nettype none
module sacs_sync #(
	parameter int W = 5,
	parameter logic [W-1:0] IDLE = '1
) (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	input wire logic ce_i,
	// data
	input wire logic [W-1:0] async_i,
	output logic [W-1:0] sync_o
);
	logic [W-1:0] meta_r;
	logic [W-1:0] sync_r;

	genvar g;
	generate
		for (g = 0; g < W; g++)
		begin : g_bit
			always_ff @(posedge core_clk_i or negedge reset_n_i)
			begin
				if (!reset_n_i)
				begin
					meta_r[g] <= IDLE[g];
					sync_r[g] <= IDLE[g];
				end
				else if (ce_i)
				begin
					meta_r[g] <= async_i[g];
					sync_r[g] <= meta_r[g];
				end
			end
		end
	endgenerate

	assign sync_o = sync_r;
endmodule
`default_nettype wire

// ### sacs_seq.sv
/*
 * control sequencer of a 13-bit successive-approximation converter:
 * strobe decode, calibration, offset null, acquisition, bit trials, result bus.
 * assumes an analog front end that sets its dac from dac_code_o and
 * answers on comp_i (high: input at or above the trial level).
 */
`timescale 1ns/100ps
`default_nettype none
module sacs_seq (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	input wire logic ce_i,
	// host strobes
	input wire logic cs_n_i,
	input wire logic wr_n_i,
	input wire logic rd_n_i,
	input wire logic cal_n_i,
	input wire logic offset_null_request_n_i,
	// result bus
	output logic [sacs_pkg::RES_W-1:0] result_bus_o,
	output logic [sacs_pkg::RES_W-1:0] result_bus_oe_o,
	// status
	output logic conv_active_n_o,
	output logic result_ready_n_o,
	// analog front end
	input wire logic comp_i,
	output logic [sacs_pkg::RES_W-1:0] dac_code_o,
	output logic hold_o,
	output logic null_input_o,
	output logic ref_input_o
);
	localparam int W = sacs_pkg::RES_W;
	localparam int CW = sacs_pkg::CNT_W;

	sacs_pkg::sacs_ctl_t ctl;
	logic [sacs_pkg::CTL_W-1:0] ctl_raw;
	sacs_pkg::sacs_state_t state_r, state_nxt;
	logic [CW-1:0] cnt_r, cnt_nxt;
	logic [W-1:0] sar_r, sar_nxt, mask_r, mask_nxt, sar_dec;
	logic [W-1:0] ofs_r, ofs_nxt, gain_r, gain_nxt, res_r, res_nxt;
	logic rdy_n_r, rdy_n_nxt, hold_r, hold_nxt, wr_q_r, wr_q_nxt, cal_q_r, cal_q_nxt;
	logic [W-1:0] data_r, data_nxt, oe_r, oe_nxt;
	logic eoc_n_r, eoc_n_nxt, null_r, null_nxt, ref_r, ref_nxt;
	logic start, abort, cal_req, read_req, test_mode;
	logic signed [W-1:0] raw_tc;
	logic signed [2*W-1:0] gprod;
	logic signed [W+1:0] corr;
	logic [W-1:0] corr_sat;

	sacs_sync #(
		.W(sacs_pkg::CTL_W),
		.IDLE(sacs_pkg::CTL_IDLE)
	) u_sync (
		.core_clk_i(core_clk_i),
		.reset_n_i(reset_n_i),
		.ce_i(ce_i),
		.async_i({cs_n_i, wr_n_i, rd_n_i, cal_n_i, offset_null_request_n_i}),
		.sync_o(ctl_raw)
	);
	assign ctl = sacs_pkg::sacs_ctl_t'(ctl_raw);

	function automatic logic [W-1:0] to_tc(input logic [W-1:0] v);
		to_tc = {~v[W-1], v[W-2:0]};
	endfunction

	// start on convert strobe rise with select low
	assign start = !ctl.cs_n && ctl.wr_n && !wr_q_r && ctl.rd_n && ctl.cal_n;
	// select and convert strobe low hold logic reset
	assign abort = !ctl.cs_n && !ctl.wr_n;
	// falling self-trim request with the other strobes idle
	assign cal_req = !ctl.cal_n && cal_q_r && ctl.cs_n && ctl.rd_n && ctl.wr_n;
	assign read_req = !ctl.cs_n && !ctl.rd_n && ctl.wr_n && ctl.cal_n;
	assign test_mode = !ctl.cs_n && !ctl.cal_n && ctl.rd_n;

	// one bit trial per clock while a trial bit is pending
	assign sar_dec = comp_i ? sar_r : (sar_r & ~mask_r);

	// stored offset and gain applied to each result
	assign raw_tc = to_tc(sar_dec);
	assign gprod = raw_tc * $signed(gain_r);
	assign corr = (W+2)'($signed(raw_tc)) - (W+2)'($signed(ofs_r))
		+ (W+2)'(gprod >>> sacs_pkg::GAIN_SHIFT);
	// clamp to the two's complement range
	always_comb
	begin
		if (corr > (W+2)'($signed(sacs_pkg::POS_MAX)))
			corr_sat = sacs_pkg::POS_MAX;
		else if (corr < (W+2)'($signed(sacs_pkg::NEG_MIN)))
			corr_sat = sacs_pkg::NEG_MIN;
		else
			corr_sat = corr[W-1:0];
	end

	always_comb
	begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		sar_nxt = sar_r;
		mask_nxt = mask_r;
		ofs_nxt = ofs_r;
		gain_nxt = gain_r;
		res_nxt = res_r;
		rdy_n_nxt = rdy_n_r;
		hold_nxt = 1'b0;
		wr_q_nxt = ctl.wr_n;
		cal_q_nxt = ctl.cal_n;
		// read releases the ready flag; a latch below wins
		if (read_req)
			rdy_n_nxt = 1'b1;
		if (mask_r != sacs_pkg::SAR_ZERO)
		begin
			sar_nxt = sar_dec | (mask_r >> 1);
			mask_nxt = mask_r >> 1;
		end
		case (state_r)
			sacs_pkg::ST_CAL:
			begin
				cnt_nxt = cnt_r - sacs_pkg::CNT_LAST;
				if (cnt_r == sacs_pkg::CAL_OFS_LAST)
				begin
					ofs_nxt = to_tc(sar_dec);
					sar_nxt = sacs_pkg::SAR_INIT;
					mask_nxt = sacs_pkg::SAR_INIT;
				end
				else if (cnt_r == sacs_pkg::CAL_GAIN_LAST)
					gain_nxt = sacs_pkg::GAIN_REF - to_tc(sar_dec);
				if (cnt_r == sacs_pkg::CNT_LAST)
					state_nxt = sacs_pkg::ST_IDLE;
			end
			sacs_pkg::ST_AZ:
			begin
				cnt_nxt = cnt_r - sacs_pkg::CNT_LAST;
				if (cnt_r == sacs_pkg::AZ_LOAD)
				begin
					sar_nxt = sacs_pkg::SAR_INIT;
					mask_nxt = sacs_pkg::SAR_INIT;
				end
				// offset null spans 26 periods before sampling
				if (cnt_r == sacs_pkg::CNT_LAST)
				begin
					ofs_nxt = to_tc(sar_dec);
					state_nxt = sacs_pkg::ST_ACQ;
					cnt_nxt = sacs_pkg::ACQ_CYC;
				end
			end
			sacs_pkg::ST_ACQ:
			begin
				cnt_nxt = cnt_r - sacs_pkg::CNT_LAST;
				if (cnt_r == sacs_pkg::CNT_LAST)
				begin
					hold_nxt = 1'b1;
					state_nxt = sacs_pkg::ST_CONV;
					cnt_nxt = sacs_pkg::SAR_CYC;
					sar_nxt = sacs_pkg::SAR_INIT;
					mask_nxt = sacs_pkg::SAR_INIT;
				end
			end
			sacs_pkg::ST_CONV:
			begin
				cnt_nxt = cnt_r - sacs_pkg::CNT_LAST;
				if (cnt_r == sacs_pkg::CNT_LAST)
				begin
					res_nxt = corr_sat;
					rdy_n_nxt = 1'b0;
					state_nxt = sacs_pkg::ST_IDLE;
				end
			end
			default:
			begin
				state_nxt = sacs_pkg::ST_IDLE;
			end
		endcase
		if (state_r != sacs_pkg::ST_CAL)
		begin
			if (abort)
			begin
				state_nxt = sacs_pkg::ST_IDLE;
				mask_nxt = sacs_pkg::SAR_ZERO;
				hold_nxt = 1'b0;
				rdy_n_nxt = 1'b1;
			end
			else if (start)
			begin
				state_nxt = ctl.offset_null_request_n ? sacs_pkg::ST_ACQ : sacs_pkg::ST_AZ;
				cnt_nxt = ctl.offset_null_request_n ? sacs_pkg::ACQ_CYC : sacs_pkg::AZ_CYC;
				mask_nxt = sacs_pkg::SAR_ZERO;
				hold_nxt = 1'b0;
				rdy_n_nxt = 1'b1;
			end
			else if (cal_req)
			begin
				state_nxt = sacs_pkg::ST_CAL;
				cnt_nxt = sacs_pkg::CAL_CYC;
				sar_nxt = sacs_pkg::SAR_INIT;
				mask_nxt = sacs_pkg::SAR_INIT;
				rdy_n_nxt = 1'b1;
			end
		end
	end

	always_comb
	begin
		data_nxt = data_r;
		oe_nxt = sacs_pkg::SAR_ZERO;
		if (read_req)
		begin
			data_nxt = res_r;
			oe_nxt = sacs_pkg::OE_ALL;
		end
		// test mode drives four bits only
		else if (test_mode)
		begin
			data_nxt = sar_r & sacs_pkg::TEST_MASK;
			oe_nxt = sacs_pkg::TEST_MASK;
		end
		// active low through conversion and calibration
		eoc_n_nxt = !(state_nxt == sacs_pkg::ST_CONV || state_nxt == sacs_pkg::ST_CAL);
		null_nxt = state_nxt == sacs_pkg::ST_AZ
			|| (state_nxt == sacs_pkg::ST_CAL && cnt_nxt >= sacs_pkg::CAL_OFS_LAST);
		ref_nxt = state_nxt == sacs_pkg::ST_CAL && cnt_nxt < sacs_pkg::CAL_OFS_LAST
			&& cnt_nxt >= sacs_pkg::CAL_GAIN_LAST;
	end

	// reset lands in a full calibration
	always_ff @(posedge core_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			state_r <= sacs_pkg::ST_CAL;
			cnt_r <= sacs_pkg::CAL_CYC;
			sar_r <= sacs_pkg::SAR_INIT;
			mask_r <= sacs_pkg::SAR_INIT;
			ofs_r <= sacs_pkg::SAR_ZERO;
			gain_r <= sacs_pkg::SAR_ZERO;
			res_r <= sacs_pkg::SAR_ZERO;
			rdy_n_r <= 1'b1;
			hold_r <= 1'b0;
			wr_q_r <= 1'b1;
			cal_q_r <= 1'b1;
			data_r <= sacs_pkg::SAR_ZERO;
			oe_r <= sacs_pkg::SAR_ZERO;
			eoc_n_r <= 1'b0;
			null_r <= 1'b1;
			ref_r <= 1'b0;
		end
		else if (ce_i)
		begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			sar_r <= sar_nxt;
			mask_r <= mask_nxt;
			ofs_r <= ofs_nxt;
			gain_r <= gain_nxt;
			res_r <= res_nxt;
			rdy_n_r <= rdy_n_nxt;
			hold_r <= hold_nxt;
			wr_q_r <= wr_q_nxt;
			cal_q_r <= cal_q_nxt;
			data_r <= data_nxt;
			oe_r <= oe_nxt;
			eoc_n_r <= eoc_n_nxt;
			null_r <= null_nxt;
			ref_r <= ref_nxt;
		end
	end

	assign result_bus_o = data_r;
	assign result_bus_oe_o = oe_r;
	assign conv_active_n_o = eoc_n_r;
	assign result_ready_n_o = rdy_n_r;
	assign dac_code_o = sar_r;
	assign hold_o = hold_r;
	assign null_input_o = null_r;
	assign ref_input_o = ref_r;

	default clocking cb @(posedge core_clk_i iff ce_i);
	endclocking
	default disable iff (!reset_n_i);

	property p_start_plain;
		start && ctl.offset_null_request_n && state_r != sacs_pkg::ST_CAL
			|=> state_r == sacs_pkg::ST_ACQ && cnt_r == sacs_pkg::ACQ_CYC;
	endproperty
	a_start_plain: assert property (p_start_plain) else $error("no sampling");
	property p_start_az;
		start && !ctl.offset_null_request_n && state_r != sacs_pkg::ST_CAL
			|=> state_r == sacs_pkg::ST_AZ && cnt_r == sacs_pkg::AZ_CYC;
	endproperty
	a_start_az: assert property (p_start_az) else $error("no offset null");
	property p_read;
		read_req |=> result_bus_oe_o == sacs_pkg::OE_ALL && result_bus_o == $past(res_r);
	endproperty
	a_read: assert property (p_read) else $error("read not driven");
	property p_cal_req;
		cal_req && state_r != sacs_pkg::ST_CAL |=> state_r == sacs_pkg::ST_CAL
			##1 !conv_active_n_o && result_ready_n_o;
	endproperty
	a_cal_req: assert property (p_cal_req) else $error("cal not taken");
	property p_test;
		test_mode |=> result_bus_oe_o == sacs_pkg::TEST_MASK;
	endproperty
	a_test: assert property (p_test) else $error("test bits wrong");
	property p_abort;
		abort && state_r != sacs_pkg::ST_CAL |=> state_r == sacs_pkg::ST_IDLE
			##1 result_ready_n_o;
	endproperty
	a_abort: assert property (p_abort) else $error("abort failed");
	property p_cal_locked;
		state_r == sacs_pkg::ST_CAL && cnt_r != sacs_pkg::CNT_LAST |=> state_r == sacs_pkg::ST_CAL;
	endproperty
	a_cal_locked: assert property (p_cal_locked) else $error("cal interrupted");
	property p_hold;
		$rose(state_r == sacs_pkg::ST_ACQ) ##1 (state_r == sacs_pkg::ST_ACQ && !abort && !start)[*6]
			|=> hold_o && state_r == sacs_pkg::ST_CONV;
	endproperty
	a_hold: assert property (p_hold) else $error("hold misplaced");
	property p_eoc;
		state_r == sacs_pkg::ST_CONV |=> !conv_active_n_o || state_r != sacs_pkg::ST_CONV;
	endproperty
	a_eoc: assert property (p_eoc) else $error("active high in conversion");
	property p_ready;
		state_r == sacs_pkg::ST_CONV && cnt_r == sacs_pkg::CNT_LAST && !abort && !start
			|=> !result_ready_n_o && res_r == $past(corr_sat);
	endproperty
	a_ready: assert property (p_ready) else $error("result not latched");
	property p_az_len;
		state_r == sacs_pkg::ST_AZ && cnt_r == sacs_pkg::CNT_LAST && !abort && !start
			|=> state_r == sacs_pkg::ST_ACQ;
	endproperty
	a_az_len: assert property (p_az_len) else $error("offset null length");
endmodule
`default_nettype wire

// ### sacs_afe_model.sv
/*
 * ideal analog front end for the converter sequencer.
 * assumes dac_code_i is offset binary and the input code is held static.
 */
`timescale 1ns/100ps
`default_nettype none
module sacs_afe_model (
	// trial level from the sequencer
	input wire logic [sacs_pkg::RES_W-1:0] dac_code_i,
	input wire logic null_input_i,
	input wire logic ref_input_i,
	// applied input as a signed code
	input wire logic [sacs_pkg::RES_W-1:0] ain_i,
	output logic comp_o
);
	logic [sacs_pkg::RES_W-1:0] level;

	always_comb
	begin
		level = null_input_i ? sacs_pkg::SAR_ZERO : (ref_input_i ? sacs_pkg::GAIN_REF : ain_i);
		comp_o = $signed(level) >= $signed(dac_code_i ^ sacs_pkg::SAR_INIT);
	end
endmodule
`default_nettype wire

// ### sar_adc_control_sequencer_tb_top.sv
/*
 * self-checking bench of the converter sequencer with an ideal front end.
 * assumes two synchroniser stages on every host strobe.
 */
`timescale 1ns/100ps
`default_nettype none
module sar_adc_control_sequencer_tb_top;
	// strobe latency: two sync stages and the state register
	localparam int SYNC = 3;
	localparam int T_HOLD = sacs_pkg::ACQ_PERIODS + SYNC;
	localparam int T_DONE = T_HOLD + sacs_pkg::RES_W;
	typedef struct packed {
		logic [12:0] code;
		logic az;
	} sacs_row_t;
	sacs_row_t rows[7] = '{'{13'h0000, 1'b0}, '{13'h0001, 1'b0}, '{13'h1fff, 1'b0},
		'{13'h0fff, 1'b0}, '{13'h1000, 1'b0}, '{13'h0abc, 1'b1}, '{13'h1543, 1'b1}};
	logic core_clk_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic ce = 1'b1;
	int stall = 0;
	sacs_pkg::sacs_ctl_t ctl = sacs_pkg::CTL_IDLE;
	logic [12:0] ain = 13'h0000;
	logic [12:0] result_bus_o;
	logic [12:0] result_bus_oe_o;
	logic [12:0] dac_code_o;
	logic conv_active_n_o;
	logic result_ready_n_o;
	logic comp_i;
	logic hold_o;
	logic null_input_o;
	logic ref_input_o;
	int n_errors = 0;
	int checks = 0;
	int nh;
	int nr;
	int n;

	always #10 core_clk_i = ~core_clk_i;

	sacs_seq uut (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .ce_i(ce),
		.cs_n_i(ctl.cs_n), .wr_n_i(ctl.wr_n), .rd_n_i(ctl.rd_n), .cal_n_i(ctl.cal_n),
		.offset_null_request_n_i(ctl.offset_null_request_n), .result_bus_o(result_bus_o),
		.result_bus_oe_o(result_bus_oe_o), .conv_active_n_o(conv_active_n_o),
		.result_ready_n_o(result_ready_n_o), .comp_i(comp_i), .dac_code_o(dac_code_o),
		.hold_o(hold_o), .null_input_o(null_input_o), .ref_input_o(ref_input_o));

	sacs_afe_model afe (.dac_code_i(dac_code_o), .null_input_i(null_input_o),
		.ref_input_i(ref_input_o), .ain_i(ain), .comp_o(comp_i));

	task automatic chk(input string what, input logic [12:0] seen, input logic [12:0] exp);
		checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task finish_test;
		$display("checks %0d errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic step(input int k);
		repeat (k)
		begin
			@(posedge core_clk_i);
			#1;
		end
	endtask

	task automatic drive(input logic cs, input logic wr, input logic rd, input logic cal,
		input logic az);
		@(posedge core_clk_i);
		ctl <= '{cs, wr, rd, cal, az};
		#1;
	endtask

	task automatic conv(input logic [12:0] code, input logic az, input int cut);
		int k;
		ain = code;
		nh = 0;
		nr = 0;
		drive(0, 0, 1, 1, ~az);
		step(3);
		drive(0, 1, 1, 1, ~az);
		for (k = 1; k <= 200 && nr == 0; k++)
		begin
			if (k == 4 && stall > 0)
			begin
				// enable low: every flop holds its value
				@(posedge core_clk_i);
				ce <= 1'b0;
				repeat (stall) @(posedge core_clk_i);
				ce <= 1'b1;
				#1;
			end
			else
				step(1);
			if (hold_o === 1'b1 && nh == 0)
				nh = k;
			if (result_ready_n_o === 1'b0)
				nr = k;
			if (k == cut)
				return;
		end
		drive(1, 1, 1, 1, ~az);
		if (nr == 0)
		begin
			n_errors++;
			finish_test();
		end
	endtask

	task automatic rd_chk(input logic [12:0] exp);
		drive(0, 1, 0, 1, 1);
		step(4);
		chk("result", result_bus_o, exp);
		chk("oe", result_bus_oe_o, sacs_pkg::OE_ALL);
		chk("ready after read", 13'(result_ready_n_o), 13'h0001);
		drive(1, 1, 1, 1, 1);
		step(4);
		chk("oe released", result_bus_oe_o, 13'h0000);
	endtask

	task automatic calib(input int poke);
		int k;
		n = 0;
		drive(1, 1, 1, 0, 1);
		drive(1, 1, 1, 1, 1);
		for (k = 1; k <= 2000 && n == 0; k++)
		begin
			if (k == poke)
				drive(0, 0, 1, 1, 1);
			else if (poke > 0 && k == poke + 3)
				drive(0, 1, 1, 1, 1);
			else
				step(1);
			if (k == 4)
				chk("active in cal", 13'(conv_active_n_o), 13'h0000);
			if (k > 4 && conv_active_n_o === 1'b1)
				n = k;
		end
		drive(1, 1, 1, 1, 1);
		chk("cal length", 13'(n >= sacs_pkg::CAL_PERIODS && n <= sacs_pkg::CAL_PERIODS + 4),
			13'h0001);
		chk("no result after cal", 13'(result_ready_n_o), 13'h0001);
	endtask

	initial
	begin
		step(1);
		chk("active in reset", 13'(conv_active_n_o), 13'h0000);
		chk("ready in reset", 13'(result_ready_n_o), 13'h0001);
		chk("oe in reset", result_bus_oe_o, 13'h0000);
		step(4);
		@(posedge core_clk_i);
		reset_n_i <= 1'b1;
		#1;
		for (n = 1; n <= 2000 && conv_active_n_o !== 1'b1; n++)
			step(1);
		chk("power-up cal", 13'(n >= sacs_pkg::CAL_PERIODS && n <= sacs_pkg::CAL_PERIODS + 2),
			13'h0001);
		$display("test power-up done");
		calib(0);
		$display("test host calibration done");
		foreach (rows[i])
		begin
			conv(rows[i].code, rows[i].az, 0);
			chk("done time", 13'(nr), 13'(T_DONE + (rows[i].az ? sacs_pkg::AZ_PERIODS : 0)));
			if (!rows[i].az)
				chk("hold time", 13'(nh), 13'(T_HOLD));
			rd_chk(rows[i].code);
		end
		$display("test conversion table done");
		conv(13'h0123, 1'b0, 0);
		conv(13'h0456, 1'b0, 12);
		chk("ready cleared by start", 13'(result_ready_n_o), 13'h0001);
		conv(13'h1e00, 1'b0, 0);
		chk("restart time", 13'(nr), 13'(T_DONE));
		rd_chk(13'h1e00);
		calib(0);
		$display("test abort done");
		calib(100);
		$display("test uninterruptible cal done");
		drive(0, 1, 1, 0, 1);
		step(4);
		chk("test mode oe", result_bus_oe_o, sacs_pkg::TEST_MASK);
		drive(0, 1, 1, 1, 1);
		drive(1, 1, 1, 1, 1);
		step(4);
		chk("test mode left", result_bus_oe_o, 13'h0000);
		$display("test factory mode done");
		stall = 8;
		conv(13'h0077, 1'b0, 0);
		stall = 0;
		chk("ce hold time", 13'(nh), 13'(T_HOLD));
		chk("ce done time", 13'(nr), 13'(T_DONE));
		rd_chk(13'h0077);
		$display("test clock enable done");
		finish_test();
	end
endmodule
`default_nettype wire
